// >>> sdsm_pkg.sv
// Constants, register map and field layout of the speed display and relay monitor
//
// What this block does
// - Display value refreshes at a programmable interval; 0.10 s after reset.
// - Scaling 0 shows hertz; scaling 1 shows kilohertz, thresholds stay in hertz.
// - Scaling 2 shows revolutions per second: frequency divided by pulses per revolution.
// - Scaling 3 shows revolutions per minute: sixty times frequency over pulses per revolution.
// - Scaling 4 shows custom units: frequency times multiplier over pulses per revolution.
// - With scaling 2 to 4, thresholds compare in display units, not hertz.
// - Pulses per revolution resets to 1 and only affects scalings 2 to 4.
// - Multiplier resets to 1 and only applies in scaling 4.
// - Input slower than the wait time (5 s means 0.2 Hz) counts as zero.
// - Standstill asserts after the standstill delay following zero-frequency detection.
// - Relay mode 3 energizes once standstill delay elapsed after zero frequency.
// - Relay mode 1 energizes when absolute speed falls below its threshold.
// - Relay mode 4 energizes only on forward overspeed, never in reverse.
// - Pulse time 0 gives static switching; nonzero gives one pulse of that length.
// - Latch select 4 makes relay 3 catch until a release event.
// - Key or control input function 7 releases the relay 3 catch.
// - Control input configuration 1 makes the input level sensitive, active high.
// - Output polarity 0 energizes each relay when its condition is true.
// - Input property 1 takes A/B quadrature trains and derives frequency and direction.
`default_nettype none
package sdsm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_NS = 10000000; // one time unit is 10 ms
  localparam int unsigned TICK_CYCLES_DFLT = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] GATE_TICKS = 7'h64; // one second measuring gate
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam int AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_REFRESH = 8'h04;
  localparam logic [7:0] OFF_PPR = 8'h08;
  localparam logic [7:0] OFF_MULT = 8'h0C;
  localparam logic [7:0] OFF_WAIT = 8'h10;
  localparam logic [7:0] OFF_STILL = 8'h14;
  localparam logic [7:0] OFF_MODES = 8'h18;
  localparam logic [7:0] OFF_THR0 = 8'h1C;
  localparam logic [7:0] OFF_PULSE0 = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h34;
  localparam logic [7:0] OFF_DISPLAY = 8'h38;
  localparam logic [7:0] OFF_FREQ = 8'h3C;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [15:0] RST_REFRESH = 16'h000A; // 0.10 s
  localparam logic [16:0] RST_PPR = 17'h00001;
  localparam logic [7:0] RST_MULT = 8'h01;
  localparam logic [15:0] RST_WAIT = 16'h01F4; // 5.00 s
  localparam logic [15:0] RST_STILL = 16'h0064; // 1.00 s
  localparam logic [11:0] RST_MODES = 12'h000;
  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_SCALE_LSB = 0;
  localparam int CTRL_QUAD_BIT = 3;
  localparam int CTRL_INCFG_BIT = 4;
  localparam int CTRL_POL_LSB = 5;
  localparam int CTRL_LATCH_LSB = 8;
  localparam int CTRL_KEYF_LSB = 11;
  localparam int CTRL_INF_LSB = 15;
  localparam logic [3:0] FUNC_RELEASE = 4'h7;
  // ****************************************
  // Scaling settings and relay modes
  // ****************************************
  localparam logic [2:0] SCALE_HZ = 3'h0;
  localparam logic [2:0] SCALE_KHZ = 3'h1;
  localparam logic [2:0] SCALE_RPS = 3'h2;
  localparam logic [2:0] SCALE_RPM = 3'h3;
  localparam logic [2:0] SCALE_CUSTOM = 3'h4;
  localparam logic [31:0] KHZ_DIV = 32'h000003E8;
  localparam logic [31:0] RPM_FACTOR = 32'h0000003C;
  localparam logic [3:0] MODE_OVER = 4'h0;
  localparam logic [3:0] MODE_UNDER = 4'h1;
  localparam logic [3:0] MODE_ZERO = 4'h2;
  localparam logic [3:0] MODE_STILL = 4'h3;
  localparam logic [3:0] MODE_FWD_OVER = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> sdsm_top.sv
// Speed display scaling, standstill detection and relay logic with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sdsm_top
  import sdsm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Encoder and control pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic remote_control_input,
  input wire logic key_enter,
  // Monitor outputs
  output logic [2:0] relay_out,
  output logic standstill,
  output logic dir_forward
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic aw_have;
    logic [AW-1:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [15:0] refresh;
    logic [16:0] ppr;
    logic [7:0] mult;
    logic [15:0] wait_t;
    logic [15:0] still_t;
    logic [11:0] modes;
    logic [2:0][31:0] thr;
    logic [2:0][15:0] pulse;
    logic a_s1, a_s2, a_prev, b_s1, b_s2, c_s1, c_s2, k_s1, k_s2;
    logic [19:0] tick_cnt;
    logic [6:0] gate_cnt;
    logic [15:0] ref_cnt;
    logic [23:0] edge_cnt;
    logic [23:0] freq;
    logic [31:0] disp;
    logic [16:0] idle;
    logic fwd;
    logic zero;
    logic still;
    logic [2:0] cond_prev;
    logic [2:0][15:0] pcnt;
    logic [2:0] raw;
    logic [2:0] latched;
    logic [2:0] relay;
  } sdsm_state_t;

  sdsm_state_t q, n;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = wd[8*b +: 8];
    return r;
  endfunction

  // Frequency in display units for a scaling setting
  function automatic logic [31:0] scale_val(input logic [2:0] sel, input logic [23:0] f,
                                            input logic [7:0] m, input logic [16:0] p);
    logic [31:0] fw;
    logic [31:0] den;
    fw = {8'h00, f};
    den = (p == 17'h00000) ? 32'h00000001 : {15'h0000, p};
    if (sel == SCALE_KHZ)
      return fw / KHZ_DIV;
    else if (sel == SCALE_RPS)
      return fw / den;
    else if (sel == SCALE_RPM)
      return 32'(fw * RPM_FACTOR) / den;
    else if (sel == SCALE_CUSTOM)
      return 32'(fw * {24'h000000, m}) / den;
    else
      return fw;
  endfunction

  // Address is a mapped register word
  function automatic logic mapped(input logic [AW-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFF_FREQ);
  endfunction

  // ****************************************
  // Derived signals
  // ****************************************
  logic tick, a_rise, release_evt, refr_evt, ctl_act;
  logic [2:0] sel;
  logic [23:0] freq_now;
  logic [31:0] scaled, cmp;

  // Time base, input edges, release and compare value
  always_comb
  begin
    tick = (q.tick_cnt == 20'(TICK_CYCLES - 1));
    refr_evt = tick && (q.ref_cnt + 16'h0001 >= q.refresh);
    a_rise = q.a_s2 && !q.a_prev;
    sel = q.ctrl[CTRL_SCALE_LSB +: 3];
    ctl_act = q.ctrl[CTRL_INCFG_BIT] ? q.c_s2 : !q.c_s2;
    release_evt = ((q.ctrl[CTRL_INF_LSB +: 4] == FUNC_RELEASE) && ctl_act)
                  || ((q.ctrl[CTRL_KEYF_LSB +: 4] == FUNC_RELEASE) && q.k_s2);
    freq_now = q.zero ? 24'h000000 : q.freq;
    scaled = scale_val(sel, freq_now, q.mult, q.ppr);
    cmp = (sel >= SCALE_RPS && sel <= SCALE_CUSTOM) ? scaled : {8'h00, freq_now};
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [3:0] md;
    logic cond;
    logic [31:0] rd;
    md = 4'h0;
    cond = 1'b0;
    rd = 32'h00000000;
    n = q;
    // Pin synchronisers
    n.a_s1 = enc_a;
    n.a_s2 = q.a_s1;
    n.a_prev = q.a_s2;
    n.b_s1 = enc_b;
    n.b_s2 = q.b_s1;
    n.c_s1 = remote_control_input;
    n.c_s2 = q.c_s1;
    n.k_s1 = key_enter;
    n.k_s2 = q.k_s1;
    // Write channels taken independently
    if (q.awready && s_axi_awvalid)
    begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid)
    begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    if (q.aw_have && q.w_have && !q.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (q.awaddr == OFF_CTRL)
        n.ctrl = merge(q.ctrl, q.wdata, q.wstrb);
      else if (q.awaddr == OFF_REFRESH)
        n.refresh = 16'(merge({16'h0000, q.refresh}, q.wdata, q.wstrb));
      else if (q.awaddr == OFF_PPR)
        n.ppr = 17'(merge({15'h0000, q.ppr}, q.wdata, q.wstrb));
      else if (q.awaddr == OFF_MULT)
        n.mult = 8'(merge({24'h000000, q.mult}, q.wdata, q.wstrb));
      else if (q.awaddr == OFF_WAIT)
        n.wait_t = 16'(merge({16'h0000, q.wait_t}, q.wdata, q.wstrb));
      else if (q.awaddr == OFF_STILL)
        n.still_t = 16'(merge({16'h0000, q.still_t}, q.wdata, q.wstrb));
      else if (q.awaddr == OFF_MODES)
        n.modes = 12'(merge({20'h00000, q.modes}, q.wdata, q.wstrb));
      for (int i = 0; i < 3; i++)
      begin
        if (q.awaddr == OFF_THR0 + 8'(4 * i))
          n.thr[i] = merge(q.thr[i], q.wdata, q.wstrb);
        else if (q.awaddr == OFF_PULSE0 + 8'(4 * i))
          n.pulse[i] = 16'(merge({16'h0000, q.pulse[i]}, q.wdata, q.wstrb));
      end
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    // Read channel answers on the edge that takes the address
    if (q.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (q.arready && s_axi_arvalid)
    begin
      if (s_axi_araddr == OFF_CTRL)
        rd = q.ctrl;
      else if (s_axi_araddr == OFF_REFRESH)
        rd = {16'h0000, q.refresh};
      else if (s_axi_araddr == OFF_PPR)
        rd = {15'h0000, q.ppr};
      else if (s_axi_araddr == OFF_MULT)
        rd = {24'h000000, q.mult};
      else if (s_axi_araddr == OFF_WAIT)
        rd = {16'h0000, q.wait_t};
      else if (s_axi_araddr == OFF_STILL)
        rd = {16'h0000, q.still_t};
      else if (s_axi_araddr == OFF_MODES)
        rd = {20'h00000, q.modes};
      else if (s_axi_araddr == OFF_STATUS)
        rd = {23'h000000, q.latched, q.relay, q.still, q.zero, q.fwd};
      else if (s_axi_araddr == OFF_DISPLAY)
        rd = q.disp;
      else if (s_axi_araddr == OFF_FREQ)
        rd = {8'h00, freq_now};
      for (int i = 0; i < 3; i++)
      begin
        if (s_axi_araddr == OFF_THR0 + 8'(4 * i))
          rd = q.thr[i];
        else if (s_axi_araddr == OFF_PULSE0 + 8'(4 * i))
          rd = {16'h0000, q.pulse[i]};
      end
      n.rvalid = 1'b1;
      n.rdata = rd;
      n.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.arready = !n.rvalid;
    // Time base and one second counting gate
    n.tick_cnt = tick ? 20'h00000 : q.tick_cnt + 20'h00001;
    if (a_rise)
      n.edge_cnt = q.edge_cnt + 24'h000001;
    if (tick)
    begin
      n.gate_cnt = q.gate_cnt + 7'h01;
      if (q.gate_cnt + 7'h01 >= GATE_TICKS)
      begin
        n.gate_cnt = 7'h00;
        n.freq = q.edge_cnt;
        n.edge_cnt = {23'h000000, a_rise};
      end
    end
    // Display refresh at the programmed interval
    if (tick)
      n.ref_cnt = refr_evt ? 16'h0000 : q.ref_cnt + 16'h0001;
    if (refr_evt)
      n.disp = scaled;
    // Direction from which channel leads
    if (a_rise)
      n.fwd = q.ctrl[CTRL_QUAD_BIT] ? !q.b_s2 : 1'b1;
    // Zero frequency and standstill from time since the last edge
    if (a_rise)
      n.idle = 17'h00000;
    else if (tick && q.idle != 17'h1FFFF)
      n.idle = q.idle + 17'h00001;
    n.zero = (q.idle >= {1'b0, q.wait_t});
    n.still = (q.idle >= {1'b0, q.wait_t} + {1'b0, q.still_t});
    // Relay conditions, pulse timing, catch and polarity
    for (int i = 0; i < 3; i++)
    begin
      md = q.modes[4 * i +: 4];
      if (md == MODE_OVER)
        cond = cmp > q.thr[i];
      else if (md == MODE_UNDER)
        cond = cmp < q.thr[i];
      else if (md == MODE_ZERO)
        cond = q.zero;
      else if (md == MODE_STILL)
        cond = q.still;
      else if (md == MODE_FWD_OVER)
        cond = q.fwd && !q.zero && (cmp > q.thr[i]);
      else
        cond = 1'b0;
      n.cond_prev[i] = cond;
      if (q.pulse[i] == 16'h0000)
      begin
        n.pcnt[i] = 16'h0000;
        n.raw[i] = cond;
      end
      else
      begin
        if (cond && !q.cond_prev[i])
          n.pcnt[i] = q.pulse[i];
        else if (tick && q.pcnt[i] != 16'h0000)
          n.pcnt[i] = q.pcnt[i] - 16'h0001;
        n.raw[i] = (n.pcnt[i] != 16'h0000);
      end
      n.latched[i] = q.ctrl[CTRL_LATCH_LSB + i]
                     && (q.raw[i] || (q.latched[i] && !release_evt));
      n.relay[i] = (q.raw[i] || q.latched[i]) ^ q.ctrl[CTRL_POL_LSB + i];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.ctrl <= RST_CTRL;
      q.refresh <= RST_REFRESH;
      q.ppr <= RST_PPR;
      q.mult <= RST_MULT;
      q.wait_t <= RST_WAIT;
      q.still_t <= RST_STILL;
      q.modes <= RST_MODES;
      q.fwd <= 1'b1;
    end
    else
      q <= n;
  end

  // Outputs straight from the state
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign relay_out = q.relay;
  assign standstill = q.still;
  assign dir_forward = q.fwd;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence refresh_at_s(logic [2:0] s);
    refr_evt && sel == s;
  endsequence

  display_hold_a: assert property (!$stable(q.disp) |-> $past(refr_evt))
    else $error("display changed outside a refresh");
  hertz_display_a: assert property (refresh_at_s(SCALE_HZ) |=> q.disp == {8'h00, $past(freq_now)})
    else $error("hertz display differs from frequency");
  rpm_display_a: assert property (refresh_at_s(SCALE_RPM) && q.ppr != 17'h00000
                                  |=> q.disp == 32'($past(freq_now) * 60) / {15'h0000, $past(q.ppr)})
    else $error("rpm display is not sixty times frequency over pulses per revolution");
  zero_detect_a: assert property (q.idle >= {1'b0, q.wait_t} && !a_rise |=> q.zero)
    else $error("slow input not taken as zero");
  standstill_order_a: assert property (q.still |-> q.zero)
    else $error("standstill without zero frequency");
  reverse_quiet_a: assert property (q.modes[11:8] == MODE_FWD_OVER && !q.fwd
                                    && q.pulse[2] == 16'h0000 |=> !q.raw[2])
    else $error("forward overspeed relay acted in reverse");
  pulse_bound_a: assert property (q.pcnt[1] != 16'h0000 |-> q.pcnt[1] <= q.pulse[1])
    else $error("pulse counter above programmed time");
  catch_hold_a: assert property (q.latched[2] && !release_evt && q.ctrl[CTRL_LATCH_LSB + 2]
                                 |=> q.latched[2])
    else $error("relay catch dropped without release");
  direction_decode_a: assert property (a_rise && q.ctrl[CTRL_QUAD_BIT] && !q.b_s2 |=> q.fwd)
    else $error("A leading B not reported forward");
  relay_polarity_a: assert property (##1 q.relay == (($past(q.raw) | $past(q.latched))
                                     ^ $past(q.ctrl[CTRL_POL_LSB +: 3])))
    else $error("relay output not condition under polarity");
endmodule
`default_nettype wire

// >>> sdsm_enc_model.sv
// Quadrature encoder model for the speed display and relay monitor
`timescale 1ns/1ps
`default_nettype none
module sdsm_enc_model
(
  // Clock and control
  input wire logic mclk,
  input wire logic run,
  input wire logic reverse,
  // Channels
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] ph_q = 2'h0;
  int cnt = 0;
  // ****************************************
  // Phase stepping
  // ****************************************
  // One quarter period every five clocks; parks with both channels low when stopped
  always @(posedge mclk)
  begin
    if (cnt == 4)
    begin
      cnt <= 0;
      if (run || ph_q != 2'h0)
        ph_q <= reverse ? ph_q - 2'h1 : ph_q + 2'h1;
    end
    else
      cnt <= cnt + 1;
  end
  // A leads B going forward, B leads A in reverse
  assign enc_a = (ph_q == 2'h1) || (ph_q == 2'h2);
  assign enc_b = (ph_q == 2'h2) || (ph_q == 2'h3);
endmodule
`default_nettype wire

// >>> sdsm_top_test.sv
// Self-checking testbench of the speed display and relay monitor
`timescale 1ns/1ps
`default_nettype none
module sdsm_top_test
  import sdsm_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [AW-1:0] s_axi_awaddr = '0;
  logic [AW-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, mult;
  logic enc_a, enc_b, standstill, dir_forward;
  logic enc_run = 1'h0, enc_rev = 1'h0, remote_control_input = 1'h0, key_enter = 1'h0;
  logic [2:0] relay_out;
  logic [31:0] seed = 32'h00006CCF; // 27855
  int n_mismatch = 0, total_checks = 0, pcnt = 0, p0 = 0;
  // ****************************************
  // Design, encoder and clock
  // ****************************************
  sdsm_top #(.TICK_CYCLES(10)) u_sdsm_top (.mclk(mclk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .enc_a(enc_a), .enc_b(enc_b),
    .remote_control_input(remote_control_input), .key_enter(key_enter), .relay_out(relay_out),
    .standstill(standstill), .dir_forward(dir_forward));
  sdsm_enc_model u_sdsm_enc_model (.mclk(mclk), .run(enc_run), .reverse(enc_rev),
    .enc_a(enc_a), .enc_b(enc_b));
  // Clock at 50 MHz
  initial
  begin
    forever #10 mclk = ~mclk;
  end
  // Cycles during which relay 2 is energized
  always @(posedge mclk)
  begin
    if (relay_out[1] === 1'h1)
      pcnt <= pcnt + 1;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Display value from frequency, pulses per revolution and multiplier
  function automatic logic [31:0] disp_exp(input logic [2:0] s, input logic [31:0] f,
    input logic [31:0] p, input logic [31:0] m);
    case (s)
      3'h0: return f;
      3'h1: return f / 32'h000003E8;
      3'h2: return f / p;
      3'h3: return 32'h0000003C * f / p;
      default: return f * m / p;
    endcase
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // AXI4-Lite write: address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge mclk);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge mclk);
      if (!aw_ok && s_axi_awready === 1'h1)
      begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1)
      begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do
      @(posedge mclk);
    while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [1:0] rsp;
    axi_wr(addr, data, rsp);
  endtask
  // AXI4-Lite read: rready held until the answer is sampled
  task automatic axi_rd(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge mclk);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
      @(posedge mclk);
    while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1)
      @(posedge mclk);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic chk_rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
    logic [31:0] v;
    logic [1:0] rsp;
    axi_rd(addr, v, rsp);
    check(what, exp, v);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  // Watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    $display("unexpected watchdog: expected end of tests seen timeout");
    test_done();
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    chk_rd(OFF_REFRESH, 32'h0000000A, "refresh reset");
    chk_rd(OFF_PPR, 32'h00000001, "ppr reset");
    chk_rd(OFF_MULT, 32'h00000001, "mult reset");
    chk_rd(OFF_WAIT, 32'h000001F4, "wait reset");
    chk_rd(OFF_STILL, 32'h00000064, "still reset");
    chk_rd(OFF_CTRL, 32'h00000000, "ctrl reset");
    axi_rd(8'h40, d, r);
    check("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(8'h41, 32'h00000005, r);
    check("misaligned bresp", 32'(RESP_SLVERR), 32'(r));
    $display("test reset_values done");
    mult = xs() % 32'h000000C8 + 32'h00000001;
    wr(OFF_PPR, 32'h00000005);
    wr(OFF_MULT, mult);
    wr(OFF_CTRL, 32'h00000008);
    enc_run <= 1'h1;
    repeat (3000) @(posedge mclk);
    chk_rd(OFF_FREQ, 32'h00000032, "frequency");
    check("dir forward", 32'h00000001, 32'(dir_forward));
    for (int s = 0; s < 5; s++)
    begin
      wr(OFF_CTRL, 32'h00000008 | 32'(s));
      repeat (300) @(posedge mclk);
      chk_rd(OFF_DISPLAY, disp_exp(3'(s), 32'h00000032, 32'h00000005, mult), "display");
    end
    $display("test scaling done");
    wr(OFF_WAIT, 32'h00000014);
    wr(OFF_STILL, 32'h0000000A);
    wr(OFF_PULSE0 + 8'h04, 32'h00000003);
    wr(OFF_THR0 + 8'h08, 32'h0000012C);
    wr(OFF_CTRL, 32'h0003BC1B);
    wr(OFF_MODES, 32'h00000413);
    p0 = pcnt;
    wr(OFF_THR0 + 8'h04, 32'h000003E8);
    repeat (300) @(posedge mclk);
    check("relay3 forward over", 32'h00000001, 32'(relay_out[2]));
    check("relay2 pulse ok", 32'h00000001, 32'(pcnt - p0 >= 20 && pcnt - p0 <= 40));
    check("relay2 after pulse", 32'h00000000, 32'(relay_out[1]));
    // Condition gone, catch holds until the key releases it
    wr(OFF_THR0 + 8'h08, 32'h0000FFFF);
    repeat (20) @(posedge mclk);
    check("relay3 held", 32'h00000001, 32'(relay_out[2]));
    key_enter <= 1'h1;
    repeat (10) @(posedge mclk);
    key_enter <= 1'h0;
    repeat (10) @(posedge mclk);
    check("relay3 key release", 32'h00000000, 32'(relay_out[2]));
    wr(OFF_THR0 + 8'h08, 32'h0000012C);
    repeat (20) @(posedge mclk);
    check("relay3 rearmed", 32'h00000001, 32'(relay_out[2]));
    $display("test forward_relays done");
    enc_rev <= 1'h1;
    repeat (300) @(posedge mclk);
    check("dir reverse", 32'h00000000, 32'(dir_forward));
    check("relay3 caught", 32'h00000001, 32'(relay_out[2]));
    remote_control_input <= 1'h1;
    repeat (10) @(posedge mclk);
    remote_control_input <= 1'h0;
    repeat (10) @(posedge mclk);
    check("relay3 released", 32'h00000000, 32'(relay_out[2]));
    wr(OFF_THR0 + 8'h04, 32'h00000064);
    p0 = pcnt;
    wr(OFF_THR0 + 8'h04, 32'h000003E8);
    repeat (100) @(posedge mclk);
    check("relay2 reverse under", 32'h00000001, 32'(pcnt - p0 >= 20 && pcnt - p0 <= 40));
    $display("test reverse_relays done");
    enc_run <= 1'h0;
    repeat (150) @(posedge mclk);
    check("standstill early", 32'h00000000, 32'(standstill));
    check("relay1 early", 32'h00000000, 32'(relay_out[0]));
    repeat (250) @(posedge mclk);
    check("standstill late", 32'h00000001, 32'(standstill));
    check("relay1 late", 32'h00000001, 32'(relay_out[0]));
    chk_rd(OFF_FREQ, 32'h00000000, "frequency zero");
    $display("test standstill done");
    test_done();
  end
endmodule
`default_nettype wire
